/* File: rhts_top.sv */
// Function
// - Answer as bus slave at 7-bit address 0x40, direction flag in bit 0.
// - 0xE5 starts humidity with clock hold, 0xF5 humidity with polling.
// - 0xE3 starts temperature with clock hold, 0xF3 with polling; new result returned.
// - 0xE0 returns temperature captured in last humidity conversion, no new conversion.
// - 0xE6 writes configuration, 0xE7 reads it, 0xFE resets it.
// - Recognise command pairs FA 0F, FC C9 and 84 B8.
// - Hold mode: acknowledge read address, stretch clock until conversion done.
// - Polling mode: refuse read address while converting, acknowledge once done.
// - Send result MSB then LSB; checksum only if host acknowledges LSB.
// - Checksum is CRC-8, polynomial x^8+x^5+x^4+1, initial value zero.
// - Checksum optional for measurements and for the FA 0F and FC C9 identity reads, else absent.
// - Never append checksum to temperature kept from humidity conversion.
// - Humidity conversion also takes temperature and keeps it.
// - Humidity code low two bits always binary 10.
// - Temperature code low two bits always binary 00.
// - Configuration read returns one byte with no checksum.
// - Configuration bit 2 enables the on-chip heater.
`timescale 1ns/100ps
`include "rhts_defines.svh"
module rhts_top
   import rhts_pkg::*;
#(
   parameter logic [31:0] SERIAL_A = 32'h1234_5678,  // Arbitrary identity value
   parameter logic [31:0] SERIAL_B = 32'h9ABC_DEF0,  // Arbitrary identity value
   parameter logic [7:0]  FW_REV   = 8'h10           // Arbitrary revision value
) (
   input  wire logic        clk_i,          // 50 MHz system clock
   input  wire logic        srst_i,         // Synchronous reset, active high
   input  wire logic        scl_i,          // Serial clock pin level
   output logic             scl_o,          // Serial clock drive value (low)
   output logic             scl_oe_o,       // Pull serial clock low
   input  wire logic        sda_i,          // Serial data pin level
   output logic             sda_o,          // Serial data drive value (low)
   output logic             sda_oe_o,       // Pull serial data low
   input  wire logic        vdd_low_i,      // Supply low status
   output logic             conv_start_o,   // One-cycle conversion request
   output logic             conv_humid_o,   // Request is humidity (else temp)
   input  wire logic        conv_done_i,    // One-cycle conversion finished
   input  wire logic [15:0] conv_hum_i,     // Raw humidity code
   input  wire logic [15:0] conv_temp_i,    // Raw temperature code
   output logic             heater_en_o     // Heater on
);

   logic [1:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        scl_d_reg;
   logic        sda_d_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;

   rhts_state_t st_reg;
   rhts_rsp_t   rsp_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic        wbyte_reg;
   logic [7:0]  cmd_reg;
   logic [2:0]  idx_reg;
   logic [7:0]  crc_reg;
   logic        rw_reg;

   logic        busy_reg;
   logic        hold_reg;
   logic [15:0] result_reg;
   logic [15:0] last_temp_reg;
   logic [7:0]  cfg_reg;
   logic [7:0]  cfg_rd;
   logic [7:0]  tx_byte;
   logic        rx_done;
   logic        meas_cmd;

   rhts_crc_if crc_bus ();

   // Both pins come from the bus, so they are synchronised first
   rhts_sync2 u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .async_i ({scl_i, sda_i}),
      .sync_o  (pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   rhts_crc8 u_crc (
      .crc (crc_bus.calc)
   );
   assign crc_bus.crc_in  = crc_reg;
   assign crc_bus.data_in = tx_byte;

   // Delayed copies for edge and condition detection
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d_reg;
   assign scl_fall  = ~scl_s & scl_d_reg;
   assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // Completed write byte, ready for decode on the eighth falling edge
   assign rx_done  = (st_reg == RHTS_RX) && scl_fall && (bit_cnt_reg == 4'h8);
   assign meas_cmd = rx_done && !wbyte_reg &&
                     (shift_reg == `RHTS_CMD_HUM_HOLD || shift_reg == `RHTS_CMD_HUM_POLL ||
                      shift_reg == `RHTS_CMD_TMP_HOLD || shift_reg == `RHTS_CMD_TMP_POLL);

   // Reserved bits read as one, supply status is live
   always_comb begin
      cfg_rd = (cfg_reg & `RHTS_CFG_WMASK) | `RHTS_CFG_ONES;
      cfg_rd[`RHTS_VDDS_BIT] = vdd_low_i;
   end

   // Response byte for the current index; past the end the bus sees ones
   always_comb begin
      tx_byte = `RHTS_IDLE_BYTE;
      case (rsp_reg)
         RHTS_RSP_MEAS: begin
            if (idx_reg == 3'h0) tx_byte = result_reg[15:8];
            else if (idx_reg == 3'h1) tx_byte = result_reg[7:0];
            else if (idx_reg == `RHTS_MEAS_CRC_IDX) tx_byte = crc_reg;
         end
         RHTS_RSP_LAST_T: begin
            // No checksum position at all for the kept temperature
            if (idx_reg == 3'h0) tx_byte = last_temp_reg[15:8];
            else if (idx_reg == 3'h1) tx_byte = last_temp_reg[7:0];
         end
         RHTS_RSP_CFG: begin
            if (idx_reg == 3'h0) tx_byte = cfg_rd;
         end
         RHTS_RSP_ID1: begin
            if (idx_reg < `RHTS_ID_CRC_IDX) tx_byte = SERIAL_A[8*(3-idx_reg) +: 8];
            else if (idx_reg == `RHTS_ID_CRC_IDX) tx_byte = crc_reg;
         end
         RHTS_RSP_ID2: begin
            if (idx_reg < `RHTS_ID_CRC_IDX) tx_byte = SERIAL_B[8*(3-idx_reg) +: 8];
            else if (idx_reg == `RHTS_ID_CRC_IDX) tx_byte = crc_reg;
         end
         RHTS_RSP_FW: begin
            if (idx_reg == 3'h0) tx_byte = FW_REV;
         end
         RHTS_RSP_NONE: begin
            tx_byte = `RHTS_IDLE_BYTE;
         end
         default: begin
            tx_byte = `RHTS_IDLE_BYTE;
         end
      endcase
   end

   // Serial engine: address, command bytes, read phase, pin drive
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_reg      <= RHTS_IDLE;
         rsp_reg     <= RHTS_RSP_NONE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         wbyte_reg   <= 1'b0;
         cmd_reg     <= 8'h00;
         idx_reg     <= 3'h0;
         crc_reg     <= `RHTS_CRC_INIT;
         rw_reg      <= 1'b0;
         sda_oe_o    <= 1'b0;
         scl_oe_o    <= 1'b0;
      end else if (bus_start) begin
         // A repeated start ends whatever phase was running
         st_reg      <= RHTS_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_o    <= 1'b0;
         scl_oe_o    <= 1'b0;
      end else if (bus_stop) begin
         st_reg   <= RHTS_IDLE;
         sda_oe_o <= 1'b0;
         scl_oe_o <= 1'b0;
      end else begin
         case (st_reg)
            RHTS_IDLE: begin
               sda_oe_o <= 1'b0;
               scl_oe_o <= 1'b0;
            end
            RHTS_ADDR: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  rw_reg <= shift_reg[0];
                  if (shift_reg[7:1] != `RHTS_ADDR) begin
                     st_reg <= RHTS_IDLE;
                  end else if (shift_reg[0] && busy_reg && !hold_reg) begin
                     st_reg <= RHTS_IDLE;
                  end else begin
                     sda_oe_o <= 1'b1;
                     st_reg   <= RHTS_ADDR_ACK;
                  end
               end
            end
            RHTS_ADDR_ACK: begin
               if (scl_fall) begin
                  sda_oe_o    <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  idx_reg     <= 3'h0;
                  crc_reg     <= `RHTS_CRC_INIT;
                  if (!rw_reg) begin
                     wbyte_reg <= 1'b0;
                     st_reg    <= RHTS_RX;
                  end else if (busy_reg) begin
                     // Hold the clock low; the host cannot run ahead
                     scl_oe_o <= 1'b1;
                     st_reg   <= RHTS_STRETCH;
                  end else begin
                     tx_reg      <= tx_byte;
                     sda_oe_o    <= ~tx_byte[7];
                     bit_cnt_reg <= 4'h1;
                     st_reg      <= RHTS_TX;
                  end
               end
            end
            RHTS_STRETCH: begin
               if (!busy_reg) begin
                  // Data leads the clock release by a cycle
                  tx_reg      <= tx_byte;
                  sda_oe_o    <= ~tx_byte[7];
                  bit_cnt_reg <= 4'h1;
                  st_reg      <= RHTS_TX;
               end
            end
            RHTS_RX: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (rx_done) begin
                  sda_oe_o <= 1'b1;
                  st_reg   <= RHTS_RX_ACK;
                  if (!wbyte_reg) begin
                     cmd_reg   <= shift_reg;
                     wbyte_reg <= 1'b1;
                     case (shift_reg)
                        `RHTS_CMD_HUM_HOLD, `RHTS_CMD_HUM_POLL,
                        `RHTS_CMD_TMP_HOLD, `RHTS_CMD_TMP_POLL: begin
                           rsp_reg <= RHTS_RSP_MEAS;
                        end
                        `RHTS_CMD_LAST_TMP: rsp_reg <= RHTS_RSP_LAST_T;
                        `RHTS_CMD_CFG_RD:   rsp_reg <= RHTS_RSP_CFG;
                        default:            rsp_reg <= RHTS_RSP_NONE;
                     endcase
                  end else begin
                     // Second byte completes a two-byte command
                     if (cmd_reg == `RHTS_CMD_ID1_A && shift_reg == `RHTS_CMD_ID1_B) begin
                        rsp_reg <= RHTS_RSP_ID1;
                     end else if (cmd_reg == `RHTS_CMD_ID2_A &&
                                  shift_reg == `RHTS_CMD_ID2_B) begin
                        rsp_reg <= RHTS_RSP_ID2;
                     end else if (cmd_reg == `RHTS_CMD_FW_A &&
                                  shift_reg == `RHTS_CMD_FW_B) begin
                        rsp_reg <= RHTS_RSP_FW;
                     end
                  end
               end
            end
            RHTS_RX_ACK: begin
               if (scl_fall) begin
                  sda_oe_o    <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  st_reg      <= RHTS_RX;
               end
            end
            RHTS_TX: begin
               scl_oe_o <= 1'b0;
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'h8) begin
                     sda_oe_o <= 1'b0;
                     st_reg   <= RHTS_TX_ACK;
                  end else begin
                     sda_oe_o    <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            RHTS_TX_ACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     // Host refused the byte: nothing more, not even a checksum
                     st_reg <= RHTS_IDLE;
                  end else begin
                     crc_reg <= crc_bus.crc_out;
                     idx_reg <= idx_reg + 3'h1;
                  end
               end else if (scl_fall) begin
                  tx_reg      <= tx_byte;
                  sda_oe_o    <= ~tx_byte[7];
                  bit_cnt_reg <= 4'h1;
                  st_reg      <= RHTS_TX;
               end
            end
            default: begin
               st_reg <= RHTS_IDLE;
            end
         endcase
      end
   end

   // Conversion control and result capture
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy_reg      <= 1'b0;
         hold_reg      <= 1'b0;
         conv_start_o  <= 1'b0;
         conv_humid_o  <= 1'b0;
         result_reg    <= 16'h0000;
         last_temp_reg <= 16'h0000;
      end else begin
         conv_start_o <= meas_cmd;
         if (meas_cmd) begin
            busy_reg     <= 1'b1;
            conv_humid_o <= (shift_reg == `RHTS_CMD_HUM_HOLD) ||
                            (shift_reg == `RHTS_CMD_HUM_POLL);
            hold_reg     <= (shift_reg == `RHTS_CMD_HUM_HOLD) ||
                            (shift_reg == `RHTS_CMD_TMP_HOLD);
         end else if (conv_done_i && busy_reg) begin
            busy_reg <= 1'b0;
            if (conv_humid_o) begin
               result_reg    <= {conv_hum_i[15:2], `RHTS_HUM_TAG};
               last_temp_reg <= {conv_temp_i[15:2], `RHTS_TMP_TAG};
            end else begin
               result_reg <= {conv_temp_i[15:2], `RHTS_TMP_TAG};
            end
         end
      end
   end

   // Configuration register; writes store only the writable bits, reset and 0xFE load RHTS_CFG_RST
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cfg_reg <= `RHTS_CFG_RST;
      end else if (rx_done && !wbyte_reg && shift_reg == `RHTS_CMD_RESET) begin
         cfg_reg <= `RHTS_CFG_RST;
      end else if (rx_done && wbyte_reg && cmd_reg == `RHTS_CMD_CFG_WR) begin
         cfg_reg <= shift_reg & `RHTS_CFG_WMASK;
      end
   end

   // Heater follows its configuration bit
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         heater_en_o <= 1'b0;
         scl_o       <= 1'b0;
         sda_o       <= 1'b0;
      end else begin
         heater_en_o <= cfg_reg[`RHTS_HTR_BIT];
         scl_o       <= 1'b0;
         sda_o       <= 1'b0;
      end
   end

endmodule

/* File: rhts_defines.svh */
`ifndef RHTS_DEFINES_SVH
`define RHTS_DEFINES_SVH

// Bus address and command codes
`define RHTS_ADDR         7'h40
`define RHTS_CMD_HUM_HOLD 8'hE5
`define RHTS_CMD_HUM_POLL 8'hF5
`define RHTS_CMD_TMP_HOLD 8'hE3
`define RHTS_CMD_TMP_POLL 8'hF3
`define RHTS_CMD_LAST_TMP 8'hE0
`define RHTS_CMD_RESET    8'hFE
`define RHTS_CMD_CFG_WR   8'hE6
`define RHTS_CMD_CFG_RD   8'hE7
`define RHTS_CMD_ID1_A    8'hFA
`define RHTS_CMD_ID1_B    8'h0F
`define RHTS_CMD_ID2_A    8'hFC
`define RHTS_CMD_ID2_B    8'hC9
`define RHTS_CMD_FW_A     8'h84
`define RHTS_CMD_FW_B     8'hB8

// Configuration register layout
`define RHTS_CFG_RST      8'h3A
`define RHTS_CFG_WMASK    8'h85
`define RHTS_CFG_ONES     8'h3A
`define RHTS_HTR_BIT      2
`define RHTS_VDDS_BIT     6

// Result tagging and checksum
`define RHTS_HUM_TAG      2'h2
`define RHTS_TMP_TAG      2'h0
`define RHTS_CRC_POLY     8'h31
`define RHTS_CRC_INIT     8'h00
`define RHTS_IDLE_BYTE    8'hFF

// Response byte positions
`define RHTS_MEAS_CRC_IDX 3'h2
`define RHTS_ID_CRC_IDX   3'h4

`endif

/* File: rhts_pkg.sv */
package rhts_pkg;

   // Serial engine states
   typedef enum logic [2:0] {
      RHTS_IDLE,
      RHTS_ADDR,
      RHTS_ADDR_ACK,
      RHTS_RX,
      RHTS_RX_ACK,
      RHTS_STRETCH,
      RHTS_TX,
      RHTS_TX_ACK
   } rhts_state_t;

   // What a read phase returns
   typedef enum logic [2:0] {
      RHTS_RSP_NONE,
      RHTS_RSP_MEAS,
      RHTS_RSP_LAST_T,
      RHTS_RSP_CFG,
      RHTS_RSP_ID1,
      RHTS_RSP_ID2,
      RHTS_RSP_FW
   } rhts_rsp_t;

endpackage

/* File: rhts_crc_if.sv */
`timescale 1ns/100ps
interface rhts_crc_if;
   logic [7:0] crc_in;
   logic [7:0] data_in;
   logic [7:0] crc_out;

   modport calc (input crc_in, input data_in, output crc_out);
   modport user (output crc_in, output data_in, input crc_out);
endinterface

/* File: rhts_crc8.sv */
`timescale 1ns/100ps
`include "rhts_defines.svh"
module rhts_crc8 (
   rhts_crc_if.calc crc    // Running checksum and next byte
);
   // One byte of CRC-8, MSB first, folded into a single cycle
   always_comb begin
      logic [7:0] c;
      c = crc.crc_in ^ crc.data_in;
      for (int i = 0; i < 8; i++) begin
         if (c[7]) begin
            c = {c[6:0], 1'b0} ^ `RHTS_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      crc.crc_out = c;
   end
endmodule

/* File: rhts_sync2.sv */
`timescale 1ns/100ps
module rhts_sync2 (
   input  wire logic       clk_i,    // System clock
   input  wire logic       srst_i,   // Synchronous reset
   input  wire logic [1:0] async_i,  // Pin levels
   output logic      [1:0] sync_o    // Synchronised levels
);
   // Two flops per bit; the bus idles high so reset to one
   for (genvar g = 0; g < 2; g++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
         end else begin
            meta_reg <= async_i[g];
            sync_reg <= meta_reg;
         end
      end
      assign sync_o[g] = sync_reg;
   end
endmodule

/* File: rhts_monitor.sv */
`timescale 1ns/100ps
module rhts_monitor (
   input wire logic        clk_i,        // System clock
   input wire logic        srst_i,       // Synchronous reset
   input wire logic        scl_i,        // Clock pin level
   input wire logic        scl_o,        // Clock drive value
   input wire logic        scl_oe_o,     // Clock stretch
   input wire logic        sda_i,        // Data pin level
   input wire logic        sda_o,        // Data drive value
   input wire logic        sda_oe_o,     // Data pulled low
   input wire logic        vdd_low_i,    // Supply low
   input wire logic        conv_start_o, // Conversion request
   input wire logic        conv_humid_o, // Humidity request
   input wire logic        conv_done_i,  // Conversion finished
   input wire logic [15:0] conv_hum_i,   // Humidity code
   input wire logic [15:0] conv_temp_i,  // Temperature code
   input wire logic        heater_en_o   // Heater on
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // Finish pulse, busy clears, data set, then clock let go
   sequence done_seen;
      conv_done_i ##2 1'b1;
   endsequence

   // Open-drain pins never drive high
   chk_scl_open_drain: assert property (scl_oe_o |-> !scl_o)
      else $error("clock pin driven high");
   chk_sda_open_drain: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin driven high");
   // Stretch ends just after the conversion
   chk_stretch_release: assert property (scl_oe_o throughout done_seen |=> !scl_oe_o)
      else $error("stretch not released after finish");
   chk_stretch_hold: assert property (scl_oe_o && !conv_done_i && !$past(conv_done_i)
      && !$past(conv_done_i, 2) |=> scl_oe_o)
      else $error("stretch released early");
   chk_stretch_rise: assert property ($rose(scl_oe_o) |-> !scl_i && !$past(scl_i))
      else $error("stretch begun while clock high");
   // Data may only move while the clock is low
   chk_data_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data changed while clock high");
   chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
      else $error("start longer than one cycle");
   chk_start_no_stretch: assert property (conv_start_o |-> !scl_oe_o)
      else $error("start while stretching");
   chk_reset_quiet: assert property ($past(srst_i) |-> !scl_oe_o && !sda_oe_o
      && !conv_start_o)
      else $error("pins driven right after reset");
   chk_humid_stable: assert property (scl_oe_o && $past(scl_oe_o) |-> $stable(conv_humid_o))
      else $error("conversion kind moved during stretch");
endmodule

bind rhts_top rhts_monitor rhts_monitor_inst (
   .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .vdd_low_i(vdd_low_i),
   .conv_start_o(conv_start_o), .conv_humid_o(conv_humid_o), .conv_done_i(conv_done_i),
   .conv_hum_i(conv_hum_i), .conv_temp_i(conv_temp_i), .heater_en_o(heater_en_o)
);

/* File: rhts_host.sv */
`timescale 1ns/100ps
module rhts_host (
   input  wire logic  clk_i,      // System clock
   input  wire logic  scl_i,      // Clock line level
   input  wire logic  sda_i,      // Data line level
   output logic       scl_oe_o,   // Pull clock low
   output logic       sda_oe_o,   // Pull data low
   output logic       obs_o,      // Unit done strobe
   output logic [8:0] obs_data_o, // Write flag and value
   output logic       stall_o     // Clock held too long
);
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
      obs_o = 1'b0;
      obs_data_o = 9'h000;
      stall_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // Hand a finished unit to the bench for one cycle
   task automatic note(input logic [8:0] v);
      obs_data_o = v;
      obs_o = 1'b1;
      tick(1);
      obs_o = 1'b0;
   endtask

   // Data set in the low phase, sampled mid high; device may stretch
   task automatic bit_io(input logic b, output logic r);
      int n = 0;
      scl_oe_o = 1'b1;
      tick(1);
      sda_oe_o = !b;
      tick(3);
      scl_oe_o = 1'b0;
      while (!scl_i && n < 4000) begin
         tick(1);
         n++;
      end
      if (n >= 4000) stall_o = 1'b1;
      tick(2);
      r = sda_i;
      tick(2);
   endtask

   // Data falls while clock is high
   task automatic start;
      scl_oe_o = 1'b1;
      tick(1);
      sda_oe_o = 1'b0;
      tick(3);
      scl_oe_o = 1'b0;
      tick(4);
      sda_oe_o = 1'b1;
      tick(4);
   endtask

   // Data rises while clock is high
   task automatic stop;
      scl_oe_o = 1'b1;
      tick(1);
      sda_oe_o = 1'b1;
      tick(3);
      scl_oe_o = 1'b0;
      tick(4);
      sda_oe_o = 1'b0;
      tick(4);
   endtask

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
      note({1'b1, 7'h00, ack});
   endtask

   // Host acknowledge decides whether the device goes on
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
      note({1'b0, d});
   endtask
endmodule

/* File: rhts_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) begin \
         failures++; \
         $display("mismatch %s expected %h seen %h", nm, e, g); \
      end \
   end
module testbench;
   localparam logic [31:0] SER_A = 32'hC0DE_2468; // Arbitrary identity value
   localparam logic [31:0] SER_B = 32'h1357_9BDF; // Arbitrary identity value
   localparam logic [7:0]  FW    = 8'h5A;         // Arbitrary revision value
   localparam logic [7:0]  MEAS [4] = '{8'hE5, 8'hF5, 8'hE3, 8'hF3};
   logic        clk_i   = 1'b0;
   logic        srst_i  = 1'b1;
   logic        vdd_low = 1'b0;
   logic        done    = 1'b0;
   logic        exp_h   = 1'b0;
   logic        watch   = 1'b1;
   logic [15:0] hum     = 16'h0000;
   logic [15:0] tmp     = 16'h0000;
   logic [15:0] last_t  = 16'h0000;
   logic [31:0] seed    = 32'h0000_0F1F; // 3871
   logic [8:0]  e;
   logic [8:0]  expq[$];
   int          failures     = 0;
   int          total_checks = 0;
   int          starts       = 0;
   wire         d_scl, d_sda, h_scl, h_sda, d_start, d_humid, heat, obs, stall;
   wire  [8:0]  obs_d;
   // Pull-ups win unless a party pulls low
   wire         scl_ln = !(d_scl || h_scl);
   wire         sda_ln = !(d_sda || h_sda);

   always #10 clk_i = !clk_i;

   rhts_top #(.SERIAL_A(SER_A), .SERIAL_B(SER_B), .FW_REV(FW)) rhts_top_inst (
      .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_ln), .scl_o(), .scl_oe_o(d_scl),
      .sda_i(sda_ln), .sda_o(), .sda_oe_o(d_sda), .vdd_low_i(vdd_low),
      .conv_start_o(d_start), .conv_humid_o(d_humid), .conv_done_i(done),
      .conv_hum_i(hum), .conv_temp_i(tmp), .heater_en_o(heat));
   rhts_host rhts_host_inst (.clk_i(clk_i), .scl_i(scl_ln), .sda_i(sda_ln),
      .scl_oe_o(h_scl), .sda_oe_o(h_sda), .obs_o(obs), .obs_data_o(obs_d), .stall_o(stall));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Bitwise checksum, MSB first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ 8'h31) : (c << 1);
      end
      return c;
   endfunction

   task automatic summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] b, input logic a);
      logic r;
      expq.push_back({1'b1, 7'h00, a});
      rhts_host_inst.wr_byte(b, r);
   endtask

   task automatic rd(input logic [7:0] v, input logic a);
      logic [7:0] d;
      expq.push_back({1'b0, v});
      rhts_host_inst.rd_byte(a, d);
   endtask

   // Only listed codes are ever sent
   task automatic cmd(input logic [15:0] c, input bit two, input bit rd_go);
      rhts_host_inst.start();
      wr(8'h80, 1'b1);
      wr(c[15:8], 1'b1);
      if (two) wr(c[7:0], 1'b1);
      if (rd_go) begin
         rhts_host_inst.start();
         wr(8'h81, 1'b1);
      end
   endtask

   // First try is refused; retries are not tallied
   task automatic poll_ack;
      logic a = 1'b0;
      rhts_host_inst.start();
      wr(8'h81, 1'b0);
      watch = 1'b0;
      for (int t = 0; t < 40 && !a; t++) begin
         rhts_host_inst.start();
         rhts_host_inst.wr_byte(8'h81, a);
      end
      watch = 1'b1;
      `CHK("poll_ack", 1'b1, a)
   endtask

   task automatic rd_cfg(input logic [7:0] v);
      cmd(16'hE700, 1'b0, 1'b1);
      rd(v, 1'b1);
      rd(8'hFF, 1'b0);
      rhts_host_inst.stop();
   endtask

   // Oldest expectation against each unit the host finishes while watch is set
   always @(posedge clk_i) begin
      if (obs && watch) begin
         e = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
         `CHK("bus_unit", e, obs_d)
      end
   end

   always @(posedge stall) begin
      failures++;
      summarize();
   end

   // Converter: random codes, slow random finish
   initial begin
      forever begin
         @(negedge clk_i);
         if (d_start) begin
            starts++;
            `CHK("conv_kind", exp_h, d_humid)
            seed = xs(seed);
            hum = seed[15:0];
            tmp = seed[31:16];
            if (exp_h) last_t = tmp;
            repeat (200 + seed[23:16]) @(negedge clk_i);
            done = 1'b1;
            @(negedge clk_i);
            done = 1'b0;
         end
      end
   end

   initial begin
      logic [15:0] v;
      logic [31:0] sn;
      logic [7:0]  c;
      int          n0;
      repeat (20) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (5) @(negedge clk_i);
      rhts_host_inst.start();
      wr(8'h82, 1'b0);
      rhts_host_inst.stop();
      // Hold and polling modes; checksum taken on humidity only
      for (int i = 0; i < 4; i++) begin
         exp_h = (i < 2);
         n0 = starts;
         cmd({MEAS[i], 8'h00}, 1'b0, !i[0]);
         if (i[0]) poll_ack();
         v = exp_h ? {hum[15:2], 2'b10} : {tmp[15:2], 2'b00};
         rd(v[15:8], 1'b1);
         rd(v[7:0], exp_h);
         if (exp_h) rd(crc8(crc8(8'h00, v[15:8]), v[7:0]), 1'b0);
         rhts_host_inst.stop();
         `CHK("conv_count", n0 + 1, starts)
         `CHK("sda_free", 1'b0, d_sda)
      end
      n0 = starts;
      cmd(16'hE000, 1'b0, 1'b1);
      rd(last_t[15:8], 1'b1);
      rd({last_t[7:2], 2'b00}, 1'b1);
      rd(8'hFF, 1'b0);
      rhts_host_inst.stop();
      `CHK("no_conv", n0, starts)
      rd_cfg(8'h3A);
      vdd_low = 1'b1;
      cmd(16'hE604, 1'b1, 1'b0);
      rhts_host_inst.stop();
      `CHK("heater_on", 1'b1, heat)
      rd_cfg(8'h7E);
      cmd(16'hFE00, 1'b0, 1'b0);
      rhts_host_inst.stop();
      `CHK("heater_off", 1'b0, heat)
      rd_cfg(8'h7A);
      // Both identity reads carry a checksum over four bytes
      for (int k = 0; k < 2; k++) begin
         sn = k ? SER_B : SER_A;
         cmd(k ? 16'hFCC9 : 16'hFA0F, 1'b1, 1'b1);
         c = 8'h00;
         for (int j = 3; j >= 0; j--) begin
            rd(sn[8*j +: 8], 1'b1);
            c = crc8(c, sn[8*j +: 8]);
         end
         rd(c, 1'b0);
         rhts_host_inst.stop();
      end
      cmd(16'h84B8, 1'b1, 1'b1);
      rd(FW, 1'b0);
      rhts_host_inst.stop();
      `CHK("pending", 0, expq.size())
      summarize();
   end
endmodule
